// file: hdl/sci_cond.sv
// Start, stop and clock edge detector on the synchronised bus lines
`timescale 1ns/10ps
`default_nettype none

module sci_cond (
   input wire logic clk_i, // Core clock
   input wire logic rst_i, // Async reset, high
   input wire logic scl_i, // Synchronised clock line
   input wire logic sda_i, // Synchronised data line
   sci_line_if.src l // Events to the slave
);
   typedef struct packed {
      logic scl;
      logic sda;
      logic idle;
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } sci_cond_type;

   sci_cond_type s_q, s_d;

   // Data moving under a high clock is only ever start or stop
   always_comb begin
      s_d.scl = scl_i;
      s_d.sda = sda_i;
      s_d.idle = scl_i & sda_i;
      s_d.start = s_q.scl & scl_i & s_q.sda & ~sda_i;
      s_d.stop = s_q.scl & scl_i & ~s_q.sda & sda_i;
      s_d.rise = ~s_q.scl & scl_i;
      s_d.fall = s_q.scl & ~scl_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= 7'h70; // Idle bus level, so no false edge after reset
      end else begin
         s_q <= s_d;
      end
   end

   assign l.sda = s_q.sda;
   assign l.idle = s_q.idle;
   assign l.start = s_q.start;
   assign l.stop = s_q.stop;
   assign l.rise = s_q.rise;
   assign l.fall = s_q.fall;
endmodule

`default_nettype wire

// file: hdl/sci_defs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

`define SCI_CTRL_OFS 8'h00
`define SCI_DEFPTR_OFS 8'h04
`define SCI_TXD_OFS 8'h08
`define SCI_STAT_OFS 8'h0C

`define SCI_CTRL_MODE_BIT 0
`define SCI_CTRL_SUB_LSB 1
`define SCI_STAT_WIN_BIT 0
`define SCI_STAT_BUSY_BIT 1
`define SCI_STAT_RXV_BIT 2
`define SCI_STAT_PTR_LSB 8
`define SCI_STAT_RXD_LSB 16

`define SCI_MODE_RST 1'b1
`define SCI_SUB_RST 2'h0
`define SCI_DEFPTR_RST 8'h00
`define SCI_TXD_RST 8'h00

// Upper five address bits; value is arbitrary
`define SCI_ADDR_HI 5'h0B
`define SCI_BYTE_BITS 4'h8

`define SCI_CLK_MHZ 50
`define SCI_WIN_US 2000
`define SCI_HS_US 10000
`define SCI_CONV_US 5000

`endif

// file: hdl/sci_line_if.sv
// Synchronised bus levels and bus events between detector and slave
`timescale 1ns/10ps
`default_nettype none

interface sci_line_if;
   logic sda;
   logic idle;
   logic start;
   logic stop;
   logic rise;
   logic fall;
   modport src (output sda, idle, start, stop, rise, fall);
   modport snk (input sda, idle, start, stop, rise, fall);
endinterface

`default_nettype wire

// file: hdl/sci_pkg.sv
// Types shared by the sensor comms slave modules
package sci_pkg;

   // Link states, Gray coded along start, address, ack, write data
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK = 3'h3,
      ST_RX = 3'h2,
      ST_TX = 3'h6,
      ST_MACK = 3'h7,
      ST_IGN = 3'h5
   } sci_st_type;

   // All state of the slave top
   typedef struct packed {
      sci_st_type st;
      logic [3:0] bcnt;
      logic [7:0] sh;
      logic rw;
      logic nack;
      logic first;
      logic sda_oe;
      logic rdy_oe;
      logic zero;
      logic win;
      logic xfer;
      logic [19:0] tmr;
      logic [19:0] hs;
      logic [7:0] ptr;
      logic [7:0] rxd;
      logic rxv;
      logic mode;
      logic [1:0] sub;
      logic [7:0] defptr;
      logic [7:0] txd;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sci_state_type;

endpackage

// file: hdl/sci_slave.sv
// Two-wire slave with communication window, ready line and APB registers
`timescale 1ns/10ps
`default_nettype none

`include "sci_defs.svh"

module sci_slave import sci_pkg::*; #(
   parameter int WIN_CYC = `SCI_WIN_US * `SCI_CLK_MHZ,
   parameter int HS_CYC = `SCI_HS_US * `SCI_CLK_MHZ,
   parameter int CONV_CYC = `SCI_CONV_US * `SCI_CLK_MHZ
) (
   input wire logic core_clk_i, // 50 MHz core clock
   input wire logic rst_i, // Async reset, high
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB direction, high writes
   input wire logic [7:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error on unmapped address
   input wire logic scl_i, // Serial clock pin level
   input wire logic sda_i, // Serial data pin level
   output logic sda_o, // Data drive level, always low
   output logic sda_oe_o, // Pulls data low when high
   input wire logic rdy_i, // Ready pin level
   output logic rdy_o, // Ready drive level, always low
   output logic rdy_oe_o // Pulls ready low when high
);
   localparam logic [19:0] WIN_LAST = 20'(WIN_CYC - 1);
   localparam logic [19:0] HS_LAST = 20'(HS_CYC - 1);
   localparam logic [19:0] CONV_LAST = 20'(CONV_CYC - 1);

   sci_state_type s_q, s_d;
   logic [2:0] sync_w;
   logic scl_s, sda_s, rdy_s;
   logic [6:0] own_addr;
   logic rx_set;
   logic rx_clr;
   logic open_now;
   logic [31:0] rd;
   logic acc_w;

   sci_line_if l ();

   // All three pins cross into the core clock first
   sci_sync #(
      .W(3)
   ) u_sync (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .d_i({scl_i, sda_i, rdy_i}),
      .q_o(sync_w)
   );

   assign scl_s = sync_w[2]; // clock is observed, never driven
   assign sda_s = sync_w[1];
   assign rdy_s = sync_w[0];

   sci_cond u_cond (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .scl_i(scl_s),
      .sda_i(sda_s),
      .l(l)
   );

   // Fixed upper bits plus the two settable sub-address bits
   assign own_addr = {`SCI_ADDR_HI, s_q.sub};

   // Register read mux, sampled during the setup cycle
   always_comb begin
      rd = 32'h0000_0000;
      case (paddr_i)
         `SCI_CTRL_OFS: begin
            rd[`SCI_CTRL_MODE_BIT] = s_q.mode;
            rd[`SCI_CTRL_SUB_LSB +: 2] = s_q.sub;
         end
         `SCI_DEFPTR_OFS: begin
            rd[7:0] = s_q.defptr;
         end
         `SCI_TXD_OFS: begin
            rd[7:0] = s_q.txd;
         end
         `SCI_STAT_OFS: begin
            rd[`SCI_STAT_WIN_BIT] = s_q.win;
            rd[`SCI_STAT_BUSY_BIT] = (s_q.st != ST_IDLE) && (s_q.st != ST_IGN);
            rd[`SCI_STAT_RXV_BIT] = s_q.rxv;
            rd[`SCI_STAT_PTR_LSB +: 8] = s_q.ptr;
            rd[`SCI_STAT_RXD_LSB +: 8] = s_q.rxd;
         end
         default: begin
            rd = 32'h0000_0000;
         end
      endcase
   end

   // Next state: serial link, window control, then register bus
   always_comb begin
      s_d = s_q;
      rx_set = 1'b0;
      rx_clr = 1'b0;
      open_now = 1'b0;
      s_d.zero = 1'b0;

      // Serial link; start and stop are honoured in every state
      if (l.start) begin
         s_d.st = ST_ADDR;
         s_d.bcnt = 4'h0;
         s_d.sda_oe = 1'b0;
      end else if (l.stop) begin
         s_d.st = ST_IDLE;
         s_d.sda_oe = 1'b0;
      end else begin
         case (s_q.st)
            ST_ADDR, ST_RX: begin
               if (l.rise && (s_q.bcnt != `SCI_BYTE_BITS)) begin
                  // Sample on the high phase, MSB first
                  s_d.sh = {s_q.sh[6:0], l.sda};
                  s_d.bcnt = s_q.bcnt + 4'h1;
               end else if (l.fall && (s_q.bcnt == `SCI_BYTE_BITS)) begin
                  if (s_q.st == ST_ADDR) begin
                     // Own address and open window, else stay off the bus
                     if (s_q.win && (s_q.sh[7:1] == own_addr)) begin
                        s_d.sda_oe = 1'b1;
                        s_d.st = ST_ACK;
                        s_d.rw = s_q.sh[0];
                        s_d.first = 1'b1;
                     end else begin
                        s_d.st = ST_IGN;
                     end
                  end else begin
                     // First write byte sets the pointer, later ones are data
                     s_d.sda_oe = 1'b1;
                     s_d.st = ST_ACK;
                     if (s_q.first) begin
                        s_d.ptr = s_q.sh;
                        s_d.first = 1'b0;
                     end else begin
                        s_d.rxd = s_q.sh;
                        rx_set = 1'b1;
                        s_d.ptr = s_q.ptr + 8'h01;
                     end
                  end
               end
            end
            ST_ACK: begin
               // Ack held across the whole ninth pulse; on its fall, released for a write, or set to the first data bit for a read
               if (l.fall) begin
                  s_d.bcnt = 4'h0;
                  if (s_q.rw) begin
                     s_d.sh = s_q.txd;
                     s_d.sda_oe = ~s_q.txd[7];
                     s_d.st = ST_TX;
                  end else begin
                     s_d.sda_oe = 1'b0;
                     s_d.st = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (l.rise && (s_q.bcnt != `SCI_BYTE_BITS)) begin
                  s_d.sh = {s_q.sh[6:0], 1'b0};
                  s_d.bcnt = s_q.bcnt + 4'h1;
               end else if (l.fall) begin
                  if (s_q.bcnt == `SCI_BYTE_BITS) begin
                     // Free the line for the master's acknowledge
                     s_d.sda_oe = 1'b0;
                     s_d.st = ST_MACK;
                     s_d.ptr = s_q.ptr + 8'h01;
                  end else begin
                     s_d.sda_oe = ~s_q.sh[7];
                  end
               end
            end
            ST_MACK: begin
               if (l.rise) begin
                  s_d.nack = l.sda;
               end else if (l.fall) begin
                  if (s_q.nack) begin
                     s_d.st = ST_IGN;
                  end else begin
                     s_d.sh = s_q.txd;
                     s_d.sda_oe = ~s_q.txd[7];
                     s_d.bcnt = 4'h0;
                     s_d.st = ST_TX;
                  end
               end
            end
            default: begin
               // Idle or another slave's traffic: wait for start or stop
               s_d.sda_oe = 1'b0;
            end
         endcase
      end

      // Window control
      if (s_q.win) begin
         if (l.start) begin
            s_d.xfer = 1'b1;
         end
         if (l.stop) begin
            // Stop ends the window even in the middle of a sequence
            s_d.win = 1'b0;
            s_d.rdy_oe = 1'b0;
            s_d.tmr = 20'h0_0000;
         end else if (s_q.mode && !s_q.xfer && !l.start) begin
            if (s_q.tmr == WIN_LAST) begin
               s_d.win = 1'b0;
               s_d.rdy_oe = 1'b0;
               s_d.tmr = 20'h0_0000;
            end else begin
               s_d.tmr = s_q.tmr + 20'h0_0001;
            end
         end
         s_d.hs = 20'h0_0000;
      end else begin
         // Conversion cycle runs while the window is closed
         if (s_q.tmr == CONV_LAST) begin
            open_now = 1'b1;
         end else begin
            s_d.tmr = s_q.tmr + 20'h0_0001;
         end
         // Master-held ready low; window opens when it lets go, if the hold count reached HS_LAST
         if (!rdy_s) begin
            if (s_q.hs != HS_LAST) begin
               s_d.hs = s_q.hs + 20'h0_0001;
            end
         end else begin
            if (s_q.hs == HS_LAST) begin
               open_now = 1'b1;
            end
            s_d.hs = 20'h0_0000;
         end
      end
      if (open_now) begin
         s_d.win = 1'b1;
         s_d.rdy_oe = 1'b1;
         s_d.ptr = s_q.defptr;
         s_d.xfer = 1'b0;
         s_d.tmr = 20'h0_0000;
         s_d.hs = 20'h0_0000;
      end

      // APB slave: answer one cycle after setup, act at the access edge
      s_d.pready = psel_i & ~penable_i;
      s_d.pslverr = 1'b0;
      if (psel_i && !penable_i) begin
         s_d.prdata = pwrite_i ? 32'h0000_0000 : rd;
         s_d.pslverr = (paddr_i != `SCI_CTRL_OFS) && (paddr_i != `SCI_DEFPTR_OFS)
            && (paddr_i != `SCI_TXD_OFS) && (paddr_i != `SCI_STAT_OFS);
      end else begin
         s_d.prdata = s_q.prdata;
      end
      if (acc_w && pwrite_i) begin
         case (paddr_i)
            `SCI_CTRL_OFS: begin
               s_d.mode = pwdata_i[`SCI_CTRL_MODE_BIT];
               s_d.sub = pwdata_i[`SCI_CTRL_SUB_LSB +: 2];
            end
            `SCI_DEFPTR_OFS: begin
               s_d.defptr = pwdata_i[7:0];
            end
            `SCI_TXD_OFS: begin
               s_d.txd = pwdata_i[7:0];
            end
            `SCI_STAT_OFS: begin
               rx_clr = pwdata_i[`SCI_STAT_RXV_BIT];
            end
            default: begin
               rx_clr = 1'b0;
            end
         endcase
      end
      // A byte landing in the clearing cycle keeps its flag
      s_d.rxv = (s_q.rxv & ~rx_clr) | rx_set;
   end

   assign acc_w = psel_i & penable_i & s_q.pready;

   // State register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.mode <= `SCI_MODE_RST;
         s_q.sub <= `SCI_SUB_RST;
         s_q.defptr <= `SCI_DEFPTR_RST;
         s_q.txd <= `SCI_TXD_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign prdata_o = s_q.prdata;
   assign pready_o = s_q.pready;
   assign pslverr_o = s_q.pslverr;
   assign sda_o = s_q.zero;
   assign sda_oe_o = s_q.sda_oe;
   assign rdy_o = s_q.zero;
   assign rdy_oe_o = s_q.rdy_oe;
endmodule

`default_nettype wire

// file: hdl/sci_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module sci_sync #(
   parameter int W = 1
) (
   input wire logic clk_i, // Core clock
   input wire logic rst_i, // Async reset, high
   input wire logic [W-1:0] d_i, // Asynchronous levels
   output logic [W-1:0] q_o // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } sci_sync_type;

   sci_sync_type s_q, s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d.meta = d_i;
      s_d.stab = s_q.meta;
   end

   // Lines idle high, so reset to high
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign q_o = s_q.stab;
endmodule

`default_nettype wire

// file: test/sci_host_mdl.sv
// Serial bus master model: clock, conditions, bytes and ready handshake
`timescale 1ns/10ps
`default_nettype none

module sci_host_mdl (
   input wire logic scl_i, // Clock line level
   input wire logic sda_i, // Data line level
   output var logic scl_lo_o, // Pulls clock low
   output var logic sda_lo_o, // Pulls data low
   output var logic rdy_lo_o // Pulls ready low
);
   logic lclk;

   // Own 16 ns tick, phase unrelated to the core clock; lines released
   initial begin
      lclk = 1'h0;
      scl_lo_o = 1'h0;
      sda_lo_o = 1'h0;
      rdy_lo_o = 1'h0;
      #3;
      forever #8 lclk = ~lclk;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge lclk);
   endtask

   // Release clock, then wait for the line itself, bounded
   task automatic up;
      scl_lo_o <= 1'h0;
      for (int i = 0; i < 40 && scl_i !== 1'h1; i++) tk(1);
   endtask

   // One bit, 160 ns: 112 ns low, 48 ns high
   task automatic bit_io(input logic v, output logic s);
      tk(3);
      sda_lo_o <= !v;
      tk(4);
      up();
      s = sda_i;
      tk(2);
      scl_lo_o <= 1'h1;
   endtask

   // Start or repeated start after a gap of n ticks
   task automatic start(input int n);
      tk(n + 3);
      sda_lo_o <= 1'h0;
      tk(4);
      up();
      tk(4);
      sda_lo_o <= 1'h1;
      tk(4);
      scl_lo_o <= 1'h1;
   endtask

   task automatic stop;
      tk(3);
      sda_lo_o <= 1'h1;
      tk(4);
      up();
      tk(4);
      sda_lo_o <= 1'h0;
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'h1, s); // ninth pulse, data released
      ack = !s;
   endtask

   task automatic rbyte(input logic mack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
      bit_io(!mack, s);
   endtask

   task automatic hshake(input int n);
      rdy_lo_o <= 1'h1;
      tk(n);
      rdy_lo_o <= 1'h0;
   endtask
endmodule

`default_nettype wire

// file: test/sci_slave_chk.sv
// Pin-level property checker for the sensor comms slave
`timescale 1ns/10ps
`default_nettype none

module sci_slave_chk #(
   parameter int WIN_CYC = 100000,
   parameter int HS_CYC = 500000
) (
   input wire logic core_clk_i, // Core clock
   input wire logic rst_i, // Async reset
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB direction
   input wire logic [7:0] paddr_i, // APB address
   input wire logic [31:0] pwdata_i, // APB write data
   input wire logic pready_o, // APB ready
   input wire logic pslverr_o, // APB error
   input wire logic scl_i, // Clock line
   input wire logic sda_i, // Data line
   input wire logic sda_o, // Data drive level
   input wire logic sda_oe_o, // Data pull
   input wire logic rdy_i, // Ready line
   input wire logic rdy_o, // Ready drive level
   input wire logic rdy_oe_o // Ready pull
);
   logic mode_q, go_q;
   logic [19:0] win_q, lo_q;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // Mode mirror, start seen in window, window age, master ready pull length
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= 1'h1;
         go_q <= 1'h0;
         win_q <= 20'h0;
         lo_q <= 20'h0;
      end else begin
         if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h00) begin
            mode_q <= pwdata_i[0];
         end
         go_q <= rdy_oe_o && (go_q || (scl_i && $past(scl_i) && $past(sda_i) && !sda_i));
         win_q <= rdy_oe_o ? win_q + 20'h1 : 20'h0;
         lo_q <= (!rdy_i && !rdy_oe_o) ? lo_q + 20'h1 : 20'h0;
      end
   end

   // Bus conditions as seen at the pins
   sequence s_start;
      scl_i && $past(scl_i) && $past(sda_i) && !sda_i;
   endsequence
   sequence s_stop;
      scl_i && $past(scl_i) && !$past(sda_i) && sda_i;
   endsequence

   a_apb_ready: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("pready is not a one-cycle answer to setup");
   a_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   a_pin_level: assert property (!sda_o && !rdy_o)
      else $error("open-drain level not low");
   a_oe_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data pull changed while clock high");
   a_ack_steady: assert property (sda_oe_o && scl_i |=> sda_oe_o || !scl_i)
      else $error("data pull dropped during clock high");
   a_ack_window: assert property ($rose(sda_oe_o) |-> rdy_oe_o)
      else $error("data pulled with window closed");
   a_start_quiet: assert property (s_start |=> !sda_oe_o [*8])
      else $error("data pulled right after start");
   a_stop_close: assert property (s_stop |-> ##[1:8] !rdy_oe_o)
      else $error("window still open after stop");
   a_win_bound: assert property (mode_q && !go_q && rdy_oe_o |-> win_q <= WIN_CYC + 4)
      else $error("timed window open too long");
   a_win_held: assert property ($fell(rdy_oe_o) && mode_q && !go_q |-> win_q >= WIN_CYC - 4)
      else $error("timed window closed too early");
   a_hs_answer: assert property ($rose(rdy_i) && lo_q >= HS_CYC + 4 |-> ##[1:8] rdy_oe_o)
      else $error("no window after ready handshake");
endmodule

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the sensor comms slave
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } sci_row_type;

   logic clk, rst, psel, pen, pwr;
   logic [7:0] paddr, rb;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, sda_oe, rdy_oe, ack, err;
   wire m_scl, m_sda, m_rdy;
   int n_errors = 0, n_tests = 0;
   // Open-drain lines with pull-ups
   wire scl = !m_scl;
   wire sda = !(m_sda || sda_oe);
   wire rdy = !(m_rdy || rdy_oe);

   // Register reset values, writable fields, read-only status, unmapped hole
   sci_row_type rows [12] = '{
      {1'h0, 8'h00, 32'h0, 32'h1, 1'h0}, {1'h0, 8'h04, 32'h0, 32'h0, 1'h0},
      {1'h0, 8'h08, 32'h0, 32'h0, 1'h0}, {1'h0, 8'h0C, 32'h0, 32'h0, 1'h0},
      {1'h1, 8'h04, 32'h5A, 32'h0, 1'h0}, {1'h0, 8'h04, 32'h0, 32'h5A, 1'h0},
      {1'h1, 8'h08, 32'hA5, 32'h0, 1'h0}, {1'h0, 8'h08, 32'h0, 32'hA5, 1'h0},
      {1'h1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 1'h0}, {1'h0, 8'h0C, 32'h0, 32'h0, 1'h0},
      {1'h1, 8'h10, 32'h1234, 32'h0, 1'h1}, {1'h0, 8'h10, 32'h0, 32'h0, 1'h1}};

   // 50 MHz core clock
   always #10 clk = ~clk;

   sci_slave #(.WIN_CYC(1000), .HS_CYC(100), .CONV_CYC(400)) uut (
      .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl), .sda_i(sda),
      .sda_o(), .sda_oe_o(sda_oe), .rdy_i(rdy), .rdy_o(), .rdy_oe_o(rdy_oe));

   sci_host_mdl host (.scl_i(scl), .sda_i(sda), .scl_lo_o(m_scl), .sda_lo_o(m_sda),
      .rdy_lo_o(m_rdy));

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'h1 && i < 40);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
      chk("pready", 32'(pready), 32'h1);
      if (pready !== 1'h1) stop_test();
   endtask

   task automatic wait_oe(input logic v, input int n);
      for (int i = 0; i < n && rdy_oe !== v; i++) @(posedge clk);
      chk("rdy_oe", 32'(rdy_oe), 32'(v));
      if (rdy_oe !== v) stop_test();
   endtask

   task automatic wr(input logic [7:0] b, input logic x);
      host.wbyte(b, ack);
      chk("ack", 32'(ack), 32'(x));
   endtask

   initial begin
      // Idle bus and held reset from time zero
      clk = 1'h0;
      rst = 1'h1;
      psel = 1'h0;
      pen = 1'h0;
      pwr = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      chk("pins", 32'({sda_oe, rdy_oe, pready, pslverr}), 32'h0);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("rdata", rd, rows[i].x);
         chk("pslverr", 32'(err), 32'(rows[i].e));
      end
      // Probe during conversions: own address, no answer
      host.start(0);
      wr(8'h58, 1'h0);
      host.stop();
      // Timed window: pointer preset, then timeout releases ready
      wait_oe(1'h1, 2000);
      apb(1'h0, 8'h0C, 32'h0);
      chk("status", rd, 32'h0000_5A01);
      wait_oe(1'h0, 1100);
      chk("rdy", 32'(rdy), 32'h1);
      // Sub-address 2 and an untimed window, then a full exchange
      apb(1'h1, 8'h00, 32'h4);
      wait_oe(1'h1, 2000);
      repeat (1200) @(posedge clk);
      chk("open", 32'(rdy_oe), 32'h1);
      host.start(1000);
      wr(8'h58, 1'h0);
      host.start(0);
      wr(8'h5C, 1'h1);
      wr(8'h10, 1'h1);
      wr(8'h3C, 1'h1);
      host.start(0);
      wr(8'h5D, 1'h1);
      host.rbyte(1'h1, rb);
      chk("rbyte", 32'(rb), 32'hA5);
      host.rbyte(1'h0, rb);
      chk("rbyte", 32'(rb), 32'hA5);
      chk("open", 32'(rdy_oe), 32'h1);
      host.stop();
      wait_oe(1'h0, 20);
      apb(1'h0, 8'h0C, 32'h0);
      chk("status", rd, 32'h003C_1304);
      apb(1'h1, 8'h0C, 32'h4);
      apb(1'h0, 8'h0C, 32'h0);
      chk("status", rd, 32'h003C_1300);
      // Master-requested window before the conversion ends
      host.hshake(150);
      chk("rdy_oe", 32'(rdy_oe), 32'h0);
      wait_oe(1'h1, 10);
      stop_test();
   end
endmodule

bind sci_slave sci_slave_chk #(.WIN_CYC(WIN_CYC), .HS_CYC(HS_CYC)) chk_i (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .rdy_i(rdy_i), .rdy_o(rdy_o), .rdy_oe_o(rdy_oe_o));

`default_nettype wire
